// ==== verilog/uart_rx_flow_regs.svh ====
`ifndef UART_RX_FLOW_REGS_SVH
`define UART_RX_FLOW_REGS_SVH

// register offsets on the 4-bit register port
`define OFS_RX_DATA          4'h0
`define OFS_RX_LEVEL         4'h1
`define OFS_RX_TRIGGER       4'h2
`define OFS_PAUSE_ONE        4'h3
`define OFS_PAUSE_TWO        4'h4
`define OFS_RESUME_ONE       4'h5
`define OFS_RESUME_TWO       4'h6
`define OFS_FLOW_STATUS      4'h7
`define OFS_FLOW_MODE        4'h8
`define OFS_MODEM_STATUS     4'h9
`define OFS_LINE_STATUS      4'ha
`define OFS_INT_STATUS       4'hb
`define OFS_SCRATCH          4'hc
`define OFS_DIVISOR_LOW      4'hd

// flow status bit positions
`define FS_TX_RESUME         3
`define FS_TX_PAUSE          2
`define FS_RX_RESUME         1
`define FS_RX_PAUSE          0

// reset values
`define RST_ZERO             8'h00
`define RST_DIVISOR_LOW      8'h01
`define RST_INT_STATUS       8'h01
`define INT_STATUS_RX        8'h04
`define RST_LINE_STATUS      8'h60
`define RST_SCRATCH          8'hff

// receive storage sizes
`define RX_FIFO_DEPTH        7'h40
`define STAGE_DEPTH          4

`endif

// ==== verilog/uart_rx_flow_pkg.sv ====
`default_nettype none
package uart_rx_flow_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		PEND_NONE   = 2'b00,
		PEND_PAUSE  = 2'b01,
		PEND_RESUME = 2'b10
	} pend_t;
endpackage
`default_nettype wire

// ==== verilog/rx_stage_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_stage_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// drain side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	// depth must be a power of two: pointers wrap by overflow
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rptr_r];

	always_comb begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + (AW+1)'(1);
		else if (pop && !push)
			count_nxt = count_r - (AW+1)'(1);
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wptr_r] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push)
				wptr_r <= wptr_r + AW'(1);
			if (pop)
				rptr_r <= rptr_r + AW'(1);
		end
	end

	// ready is registered so the top drives it from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r  <= '0;
			in_ready <= 1'b0;
		end else begin
			count_r  <= count_nxt;
			in_ready <= (count_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule // rx_stage_fifo
`default_nettype wire

// ==== verilog/uart_rx_level_flow_char_status.sv ====
// Behaviour
// - A read-only level count shows how many characters sit in the receive FIFO, 0 to 64.
// - An 8-bit write to the write-only trigger register sets the receive threshold, 0 to 64.
// - The receive interrupt rises once the FIFO level is nonzero and reaches the programmed threshold.
// - Four write-only registers hold two pause and two resume characters for flow control.
// - The flow status register is held at zero whenever software flow control is off.
// - Status bit 3 marks that resume characters were sent last and clears on read.
// - Status bit 2 marks that pause characters were sent last and clears on read.
// - Status bit 1 marks that resume characters were received last and clears on read.
// - Status bit 0 marks that pause characters were received last and clears on read.
// - Reset clears the modem change bits and loads the upper bits from the modem pins.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_flow_regs.svh"
module uart_rx_level_flow_char_status (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RESETN,
	// register port
	input  wire logic [3:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	output logic            REG_RVALID,
	// receive character stream
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_VALID,
	output logic            RX_READY,
	// transmitter control character events
	input  wire logic       TX_SENT_RESUME,
	input  wire logic       TX_SENT_PAUSE,
	// modem input pins
	input  wire logic [3:0] MODEM_IN,
	// block status outputs
	output logic            RX_INT,
	output logic            TX_HOLD,
	// pin drive requests
	input  wire logic       TX_BIT,
	input  wire logic       IR_BIT,
	input  wire logic       RTS_REQ_N,
	input  wire logic       DTR_REQ_N,
	input  wire logic       CFG_CLK_REQ,
	input  wire logic       CFG_SEL_REQ,
	input  wire logic       CFG_DATA_REQ,
	// pins
	output logic            SER_TX,
	output logic            INFRARED_TX_OUT,
	output logic            RTS_N,
	output logic            DTR_N,
	output logic            CFG_MEM_SERIAL_CLK,
	output logic            CFG_MEM_SELECT,
	output logic            CFG_MEM_SERIAL_IN
);
	uart_rx_flow_pkg::byte_t rxmem [64];
	logic [5:0]              wptr_r;
	logic [5:0]              rptr_r;
	logic [6:0]              level_r;
	uart_rx_flow_pkg::byte_t trig_r;
	uart_rx_flow_pkg::byte_t pause1_r;
	uart_rx_flow_pkg::byte_t pause2_r;
	uart_rx_flow_pkg::byte_t resume1_r;
	uart_rx_flow_pkg::byte_t resume2_r;
	uart_rx_flow_pkg::byte_t status_r;
	uart_rx_flow_pkg::byte_t status_nxt;
	uart_rx_flow_pkg::byte_t msr_r;
	uart_rx_flow_pkg::byte_t scratch_r;
	uart_rx_flow_pkg::byte_t divisor_low_r;
	logic [3:0]              mode_r;
	uart_rx_flow_pkg::pend_t pend_r;
	uart_rx_flow_pkg::pend_t pend_nxt;
	uart_rx_flow_pkg::byte_t stage_data;
	logic                    stage_valid;
	logic                    stage_take;
	logic                    pair_mode;
	logic                    single_pause;
	logic                    single_resume;
	logic                    rx_pause_hit;
	logic                    rx_resume_hit;
	logic                    push;
	logic                    pop;
	logic                    flow_on;

	function automatic logic acc(input logic s, input logic [3:0] a,
		input logic [3:0] o);
		acc = s && (a == o);
	endfunction

	function automatic logic cmp(input uart_rx_flow_pkg::byte_t c,
		input uart_rx_flow_pkg::byte_t one,
		input uart_rx_flow_pkg::byte_t two, input logic [1:0] m);
		cmp = (m[1] && (c == one)) || (m[0] && (c == two));
	endfunction

	// small staging buffer; stalls the source when the main FIFO is full
	rx_stage_fifo #(
		.WIDTH (8),
		.DEPTH (`STAGE_DEPTH)
	) u_stage (
		.clk       (REF_CLK),
		.rst_n     (RESETN),
		.in_data   (RX_DATA),
		.in_valid  (RX_VALID),
		.in_ready  (RX_READY),
		.out_data  (stage_data),
		.out_valid (stage_valid),
		.out_ready (stage_take)
	);

	assign flow_on    = (mode_r != 4'h0);
	assign stage_take = stage_valid && (level_r != `RX_FIFO_DEPTH);
	assign pair_mode  = (mode_r == 4'hf);

	assign single_pause = !pair_mode
		&& cmp(stage_data, pause1_r, pause2_r, mode_r[1:0]);
	assign single_resume = !pair_mode && !single_pause
		&& cmp(stage_data, resume1_r, resume2_r, mode_r[1:0]);
	assign rx_pause_hit = stage_take && (single_pause || (pair_mode
		&& pend_r == uart_rx_flow_pkg::PEND_PAUSE
		&& stage_data == pause2_r));
	assign rx_resume_hit = stage_take && !rx_pause_hit
		&& (single_resume || (pair_mode
		&& pend_r == uart_rx_flow_pkg::PEND_RESUME
		&& stage_data == resume2_r));

	// single-character matches are consumed, not stored
	assign push = stage_take && !single_pause && !single_resume;
	assign pop  = acc(REG_RD, REG_ADDR, `OFS_RX_DATA) && (level_r != 7'h0);

	always_comb begin
		pend_nxt = pend_r;
		if (!pair_mode)
			pend_nxt = uart_rx_flow_pkg::PEND_NONE;
		else if (stage_take) begin
			if (stage_data == pause1_r)
				pend_nxt = uart_rx_flow_pkg::PEND_PAUSE;
			else if (stage_data == resume1_r)
				pend_nxt = uart_rx_flow_pkg::PEND_RESUME;
			else
				pend_nxt = uart_rx_flow_pkg::PEND_NONE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			pend_r <= uart_rx_flow_pkg::PEND_NONE;
		else
			pend_r <= pend_nxt;
	end

	always_ff @(posedge REF_CLK) begin
		if (push)
			rxmem[wptr_r] <= stage_data;
	end

	// level count follows push and pop
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			wptr_r  <= 6'h0;
			rptr_r  <= 6'h0;
			level_r <= 7'h0;
		end else begin
			if (push)
				wptr_r <= wptr_r + 6'h1;
			if (pop)
				rptr_r <= rptr_r + 6'h1;
			if (push && !pop)
				level_r <= level_r + 7'h1;
			else if (pop && !push)
				level_r <= level_r - 7'h1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			trig_r        <= `RST_ZERO;
			pause1_r      <= `RST_ZERO;
			pause2_r      <= `RST_ZERO;
			resume1_r     <= `RST_ZERO;
			resume2_r     <= `RST_ZERO;
			mode_r        <= 4'h0;
			scratch_r     <= `RST_SCRATCH;
			divisor_low_r <= `RST_DIVISOR_LOW;
		end else begin
			if (acc(REG_WR, REG_ADDR, `OFS_RX_TRIGGER))
				trig_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_PAUSE_ONE))
				pause1_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_PAUSE_TWO))
				pause2_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_RESUME_ONE))
				resume1_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_RESUME_TWO))
				resume2_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_FLOW_MODE))
				mode_r <= REG_WDATA[3:0];
			if (acc(REG_WR, REG_ADDR, `OFS_SCRATCH))
				scratch_r <= REG_WDATA;
			if (acc(REG_WR, REG_ADDR, `OFS_DIVISOR_LOW))
				divisor_low_r <= REG_WDATA;
		end
	end

	// events after the read clear, so a same-cycle event survives
	always_comb begin
		status_nxt = status_r;
		if (acc(REG_RD, REG_ADDR, `OFS_FLOW_STATUS))
			status_nxt = `RST_ZERO;
		if (TX_SENT_RESUME) begin
			status_nxt[`FS_TX_RESUME] = 1'b1;
			status_nxt[`FS_TX_PAUSE]  = 1'b0;
		end
		if (TX_SENT_PAUSE) begin
			status_nxt[`FS_TX_PAUSE]  = 1'b1;
			status_nxt[`FS_TX_RESUME] = 1'b0;
		end
		if (rx_resume_hit) begin
			status_nxt[`FS_RX_RESUME] = 1'b1;
			status_nxt[`FS_RX_PAUSE]  = 1'b0;
		end
		if (rx_pause_hit) begin
			status_nxt[`FS_RX_PAUSE]  = 1'b1;
			status_nxt[`FS_RX_RESUME] = 1'b0;
		end
		status_nxt[7:4] = 4'h0;
		// forced clear while flow control is off
		if (!flow_on)
			status_nxt = `RST_ZERO;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			status_r <= `RST_ZERO;
		else
			status_r <= status_nxt;
	end

	// modem levels caught in reset, change bits cleared
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			msr_r <= {MODEM_IN, 4'h0};
		else begin
			msr_r[7:4] <= MODEM_IN;
			msr_r[3:0] <= (acc(REG_RD, REG_ADDR, `OFS_MODEM_STATUS)
				? 4'h0 : msr_r[3:0]) | (MODEM_IN ^ msr_r[7:4]);
		end
	end

	// interrupt while level is nonzero and at or above the threshold
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			RX_INT <= 1'b0;
		else
			RX_INT <= ({1'b0, level_r} >= trig_r) && (level_r != 7'h0);
	end

	// transmitter is held between a received pause and resume
	always_ff @(posedge REF_CLK) begin
		if (!RESETN || mode_r[1:0] == 2'b00)
			TX_HOLD <= 1'b0;
		else if (rx_pause_hit)
			TX_HOLD <= 1'b1;
		else if (rx_resume_hit)
			TX_HOLD <= 1'b0;
	end

	// write-only registers read back as zero
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			REG_RDATA  <= `RST_ZERO;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				unique case (REG_ADDR)
				`OFS_RX_DATA:
					REG_RDATA <= (level_r != 7'h0) ? rxmem[rptr_r] : `RST_ZERO;
				`OFS_RX_LEVEL:     REG_RDATA <= {1'b0, level_r};
				`OFS_FLOW_STATUS:  REG_RDATA <= status_r;
				`OFS_FLOW_MODE:    REG_RDATA <= {4'h0, mode_r};
				`OFS_MODEM_STATUS: REG_RDATA <= msr_r;
				`OFS_LINE_STATUS:
					REG_RDATA <= `RST_LINE_STATUS | {7'h0, level_r != 7'h0};
				`OFS_INT_STATUS:
					REG_RDATA <= RX_INT ? `INT_STATUS_RX : `RST_INT_STATUS;
				`OFS_SCRATCH:      REG_RDATA <= scratch_r;
				`OFS_DIVISOR_LOW:  REG_RDATA <= divisor_low_r;
				default:           REG_RDATA <= `RST_ZERO;
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			SER_TX             <= 1'b1;
			RTS_N              <= 1'b1;
			DTR_N              <= 1'b1;
			INFRARED_TX_OUT    <= 1'b0;
			CFG_MEM_SERIAL_CLK <= 1'b0;
			CFG_MEM_SELECT     <= 1'b0;
			CFG_MEM_SERIAL_IN  <= 1'b0;
		end else begin
			SER_TX             <= TX_BIT;
			RTS_N              <= RTS_REQ_N;
			DTR_N              <= DTR_REQ_N;
			INFRARED_TX_OUT    <= IR_BIT;
			CFG_MEM_SERIAL_CLK <= CFG_CLK_REQ;
			CFG_MEM_SELECT     <= CFG_SEL_REQ;
			CFG_MEM_SERIAL_IN  <= CFG_DATA_REQ;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);

	property p_level_max;
		level_r <= `RX_FIFO_DEPTH;
	endproperty
	a_level_max: assert property (p_level_max)
		else $error("level count above 64");

	property p_level_step;
		(push && !pop) |=> level_r == $past(level_r) + 7'h1;
	endproperty
	a_level_step: assert property (p_level_step)
		else $error("level count missed a push");

	property p_trig_write;
		acc(REG_WR, REG_ADDR, `OFS_RX_TRIGGER) |=> trig_r == $past(REG_WDATA);
	endproperty
	a_trig_write: assert property (p_trig_write)
		else $error("trigger write not stored");

	property p_rx_int;
		({1'b0, level_r} >= trig_r && level_r != 7'h0) |=> RX_INT;
	endproperty
	a_rx_int: assert property (p_rx_int)
		else $error("interrupt missing at threshold");

	property p_pause_write;
		acc(REG_WR, REG_ADDR, `OFS_PAUSE_TWO) |=> pause2_r == $past(REG_WDATA);
	endproperty
	a_pause_write: assert property (p_pause_write)
		else $error("pause character write not stored");

	property p_flow_off;
		!flow_on |=> status_r == `RST_ZERO;
	endproperty
	a_flow_off: assert property (p_flow_off)
		else $error("status not zero with flow control off");

	property p_tx_resume;
		(flow_on && TX_SENT_RESUME && !TX_SENT_PAUSE)
			|=> status_r[`FS_TX_RESUME] && !status_r[`FS_TX_PAUSE];
	endproperty
	a_tx_resume: assert property (p_tx_resume)
		else $error("sent resume not recorded");

	property p_tx_pause;
		(flow_on && TX_SENT_PAUSE) |=> status_r[`FS_TX_PAUSE];
	endproperty
	a_tx_pause: assert property (p_tx_pause)
		else $error("sent pause not recorded");

	property p_rx_resume;
		(flow_on && rx_resume_hit) |=> status_r[`FS_RX_RESUME] && !TX_HOLD;
	endproperty
	a_rx_resume: assert property (p_rx_resume)
		else $error("received resume not recorded");

	property p_rx_pause;
		(flow_on && rx_pause_hit) |=> status_r[`FS_RX_PAUSE] && TX_HOLD;
	endproperty
	a_rx_pause: assert property (p_rx_pause)
		else $error("received pause not recorded");

	property p_read_clear;
		(acc(REG_RD, REG_ADDR, `OFS_FLOW_STATUS) && !TX_SENT_RESUME
			&& !TX_SENT_PAUSE && !rx_pause_hit && !rx_resume_hit)
			|=> status_r == `RST_ZERO;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status not cleared by read");

	property p_msr_reset;
		disable iff (1'b0) !RESETN |=> msr_r == {$past(MODEM_IN), 4'h0};
	endproperty
	a_msr_reset: assert property (p_msr_reset)
		else $error("modem status reset value wrong");

	property p_reg_reset;
		disable iff (1'b0) !RESETN |=> scratch_r == `RST_SCRATCH
			&& divisor_low_r == `RST_DIVISOR_LOW && level_r == 7'h0;
	endproperty
	a_reg_reset: assert property (p_reg_reset)
		else $error("register reset value wrong");

	property p_pin_reset;
		disable iff (1'b0) !RESETN |=> SER_TX && RTS_N && DTR_N
			&& !INFRARED_TX_OUT && !CFG_MEM_SELECT;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("pin reset level wrong");
endmodule // uart_rx_level_flow_char_status
`default_nettype wire

// ==== bench/remote_serial_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev (
	// clock
	input  wire logic       clk,
	// character stream toward the receiver
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready
);
	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
	end

	// ready is registered, so its level at the falling edge is what
	// the next rising edge will take
	task automatic send(input logic [7:0] ch, input int gap);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		rx_data  = ch;
		rx_valid = 1'b1;
		while (rx_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		rx_valid = 1'b0;
		// stale data must never look like a fresh character
		rx_data  = ~ch;
	endtask
endmodule // remote_serial_dev
`default_nettype wire

// ==== bench/tb_uart_rx_level_flow_char_status.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_flow_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_uart_rx_level_flow_char_status;
	logic       REF_CLK, RESETN = 1'b0;
	logic [3:0] REG_ADDR = 4'h0;
	logic       REG_WR = 1'b0, REG_RD = 1'b0;
	logic [7:0] REG_WDATA = 8'h00, REG_RDATA, RX_DATA;
	logic       REG_RVALID, RX_VALID, RX_READY, RX_INT, TX_HOLD;
	logic       TX_SENT_RESUME = 1'b0, TX_SENT_PAUSE = 1'b0;
	logic [3:0] MODEM_IN = 4'ha;
	logic [6:0] pin_req = 7'h00, pin_out;
	logic       SER_TX, INFRARED_TX_OUT, RTS_N, DTR_N;
	logic       CFG_MEM_SERIAL_CLK, CFG_MEM_SELECT, CFG_MEM_SERIAL_IN;
	logic [7:0] exp_q[$], data_q[$], exp_v, ch;
	int         err_total = 0, checked = 0, i;
	int         seed = 32'hda0ce02d;

	assign pin_out = {SER_TX, INFRARED_TX_OUT, RTS_N, DTR_N,
		CFG_MEM_SERIAL_CLK, CFG_MEM_SELECT, CFG_MEM_SERIAL_IN};

	uart_rx_level_flow_char_status i_dut (
		.REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
		.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
		.TX_SENT_RESUME(TX_SENT_RESUME), .TX_SENT_PAUSE(TX_SENT_PAUSE),
		.MODEM_IN(MODEM_IN), .RX_INT(RX_INT), .TX_HOLD(TX_HOLD),
		.TX_BIT(pin_req[6]), .IR_BIT(pin_req[5]), .RTS_REQ_N(pin_req[4]),
		.DTR_REQ_N(pin_req[3]), .CFG_CLK_REQ(pin_req[2]),
		.CFG_SEL_REQ(pin_req[1]), .CFG_DATA_REQ(pin_req[0]),
		.SER_TX(SER_TX), .INFRARED_TX_OUT(INFRARED_TX_OUT),
		.RTS_N(RTS_N), .DTR_N(DTR_N),
		.CFG_MEM_SERIAL_CLK(CFG_MEM_SERIAL_CLK),
		.CFG_MEM_SELECT(CFG_MEM_SELECT),
		.CFG_MEM_SERIAL_IN(CFG_MEM_SERIAL_IN)
	);

	remote_serial_dev i_peer (
		.clk(REF_CLK), .rx_data(RX_DATA), .rx_valid(RX_VALID),
		.rx_ready(RX_READY)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge REF_CLK);
		REG_ADDR  = a;
		REG_WDATA = d;
		REG_WR    = 1'b1;
		@(negedge REF_CLK);
		REG_WR = 1'b0;
	endtask

	// the answer is judged by the watcher below, in request order
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge REF_CLK);
		REG_ADDR = a;
		REG_RD   = 1'b1;
		exp_q.push_back(e);
		@(negedge REF_CLK);
		REG_RD = 1'b0;
	endtask

	task automatic pulse_tx(input logic resume);
		@(negedge REF_CLK);
		if (resume) TX_SENT_RESUME = 1'b1;
		else TX_SENT_PAUSE = 1'b1;
		@(negedge REF_CLK);
		TX_SENT_RESUME = 1'b0;
		TX_SENT_PAUSE  = 1'b0;
	endtask

	task automatic send_data(input int n);
		for (int k = 0; k < n; k++) begin
			ch = {2'b01, 6'($random(seed))};
			data_q.push_back(ch);
			i_peer.send(ch, int'($random(seed) & 32'h3));
		end
		repeat (4) @(negedge REF_CLK);
	endtask

	task automatic end_of_test();
		if (exp_q.size() != 0) err_total++;
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// register answers stand one cycle, so the falling edge sees them
	always @(negedge REF_CLK) begin
		if (REG_RVALID === 1'b1) begin
			exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
			`CHK(REG_RDATA, exp_v)
		end
	end

	initial begin
		#600000;
		err_total++;
		end_of_test();
	end

	initial begin
		pin_req = 7'b0100111;
		repeat (5) @(negedge REF_CLK);
		`CHK(pin_out, 7'b1011000)
		repeat (5) @(negedge REF_CLK);
		RESETN = 1'b1;
		rd(`OFS_RX_LEVEL, 8'h00);
		rd(`OFS_FLOW_STATUS, 8'h00);
		rd(`OFS_LINE_STATUS, 8'h60);
		rd(`OFS_INT_STATUS, 8'h01);
		rd(`OFS_SCRATCH, 8'hff);
		rd(`OFS_DIVISOR_LOW, 8'h01);
		rd(`OFS_MODEM_STATUS, 8'ha0);
		wr(`OFS_RX_LEVEL, 8'h33);
		rd(`OFS_RX_LEVEL, 8'h00);
		rd(`OFS_RX_TRIGGER, 8'h00);
		rd(4'he, 8'h00);
		rd(`OFS_RX_DATA, 8'h00);
		wr(`OFS_PAUSE_ONE, 8'h13);
		wr(`OFS_PAUSE_TWO, 8'h93);
		wr(`OFS_RESUME_ONE, 8'h11);
		wr(`OFS_RESUME_TWO, 8'h91);
		wr(`OFS_FLOW_MODE, 8'h0a);
		wr(`OFS_RX_TRIGGER, 8'h03);
		send_data(2);
		`CHK(RX_INT, 1'b0)
		rd(`OFS_RX_LEVEL, 8'h02);
		send_data(1);
		`CHK(RX_INT, 1'b1)
		rd(`OFS_INT_STATUS, 8'h04);
		i_peer.send(8'h13, 0);
		repeat (4) @(negedge REF_CLK);
		rd(`OFS_FLOW_STATUS, 8'h01);
		rd(`OFS_FLOW_STATUS, 8'h00);
		i_peer.send(8'h11, 0);
		repeat (4) @(negedge REF_CLK);
		rd(`OFS_FLOW_STATUS, 8'h02);
		rd(`OFS_RX_LEVEL, 8'h03);
		pulse_tx(1'b0);
		rd(`OFS_FLOW_STATUS, 8'h04);
		pulse_tx(1'b0);
		pulse_tx(1'b1);
		rd(`OFS_FLOW_STATUS, 8'h08);
		rd(`OFS_FLOW_STATUS, 8'h00);
		// flow control off before each new setting
		wr(`OFS_FLOW_MODE, 8'h00);
		wr(`OFS_FLOW_MODE, 8'h09);
		i_peer.send(8'h93, 0);
		pulse_tx(1'b1);
		`CHK(TX_HOLD, 1'b1)
		rd(`OFS_FLOW_STATUS, 8'h09);
		wr(`OFS_FLOW_MODE, 8'h00);
		wr(`OFS_FLOW_MODE, 8'h0f);
		// pair sequences are matched and stored
		data_q.push_back(8'h13);
		data_q.push_back(8'h93);
		data_q.push_back(8'h11);
		data_q.push_back(8'h91);
		i_peer.send(8'h13, 0);
		i_peer.send(8'h93, 0);
		repeat (4) @(negedge REF_CLK);
		rd(`OFS_FLOW_STATUS, 8'h01);
		`CHK(TX_HOLD, 1'b1)
		i_peer.send(8'h11, 0);
		i_peer.send(8'h91, 0);
		pulse_tx(1'b1);
		rd(`OFS_FLOW_STATUS, 8'h0a);
		`CHK(TX_HOLD, 1'b0)
		pulse_tx(1'b0);
		wr(`OFS_FLOW_MODE, 8'h00);
		rd(`OFS_FLOW_STATUS, 8'h00);
		pulse_tx(1'b0);
		rd(`OFS_FLOW_STATUS, 8'h00);
		while (data_q.size() > 0) rd(`OFS_RX_DATA, data_q.pop_front());
		rd(`OFS_RX_LEVEL, 8'h00);
		// fill to the top, then drain
		wr(`OFS_RX_TRIGGER, 8'h40);
		send_data(63);
		`CHK(RX_INT, 1'b0)
		send_data(5);
		`CHK(RX_READY, 1'b0)
		`CHK(RX_INT, 1'b1)
		rd(`OFS_RX_LEVEL, 8'h40);
		while (data_q.size() > 0) rd(`OFS_RX_DATA, data_q.pop_front());
		rd(`OFS_RX_LEVEL, 8'h00);
		rd(`OFS_LINE_STATUS, 8'h60);
		// second reset with new modem levels
		wr(`OFS_SCRATCH, 8'h5a);
		MODEM_IN = 4'h5;
		repeat (2) @(negedge REF_CLK);
		RESETN = 1'b0;
		repeat (3) @(negedge REF_CLK);
		`CHK(pin_out, 7'b1011000)
		RESETN = 1'b1;
		rd(`OFS_MODEM_STATUS, 8'h50);
		rd(`OFS_SCRATCH, 8'hff);
		for (i = 0; i < 8; i++) begin
			@(negedge REF_CLK);
			pin_req = 7'($random(seed));
			@(negedge REF_CLK);
			`CHK(pin_out, pin_req)
		end
		repeat (4) @(negedge REF_CLK);
		end_of_test();
	end
endmodule // tb_uart_rx_level_flow_char_status
`default_nettype wire
